// >>> core/dpr_ram.sv
// Overview of operation
// - Independent mode gives each port its clock
// - Port registers follow their own port clock
// - Per-port clock enable and clear, port-local only
// - Dual-port clock modes clear every port register but the read strobe
// - In/out clock mode for true and simple
// - Input clock captures inputs, output clock data out
// - Separate enables and clears, input versus output
// - Simple dual-port read/write mode, two clocks
// - Write clock captures data, address, write strobe
// - Read clock captures read address, strobe, output
// - Each clock own enable; both sides clearable
// - Read strobe register has no clear
// - Single-port mode for non-overlapping read/write
// - Two single-port memories, each 2K bits
// - Write strobe alone selects read or write
// - Lane selects default on; set offsets still mask lanes
`timescale 1ns/1ns
`default_nettype none
module dpr_ram
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [2:0] mode_in,
	input wire logic in_tick_a_in,
	input wire logic in_ce_a_in,
	input wire logic in_clr_a_in,
	input wire logic out_tick_a_in,
	input wire logic out_ce_a_in,
	input wire logic out_clr_a_in,
	input wire logic [7:0] addr_a_in,
	input wire logic [15:0] wdata_a_in,
	input wire logic wr_a_in,
	input wire logic [1:0] byte_off_a_in,
	output logic [15:0] rdata_a_out,
	input wire logic in_tick_b_in,
	input wire logic in_ce_b_in,
	input wire logic in_clr_b_in,
	input wire logic out_tick_b_in,
	input wire logic out_ce_b_in,
	input wire logic out_clr_b_in,
	input wire logic [7:0] addr_b_in,
	input wire logic [15:0] wdata_b_in,
	input wire logic wr_b_in,
	input wire logic [1:0] byte_off_b_in,
	input wire logic rd_b_in,
	output logic [15:0] rdata_b_out
);
	logic [dpr_pkg::DATA_W-1:0] mem [0:dpr_pkg::DEPTH-1];
	logic rden_q;

	dpr_pkg::dpr_mode_type mode;
	wire logic is_io_true;
	wire logic is_io_simple;
	wire logic is_rw;
	wire logic is_single;
	wire logic is_simple;
	wire logic use_out_clk;

	wire logic [1:0] in_tick;
	wire logic [1:0] in_ce;
	wire logic [1:0] in_clr;
	wire logic [1:0] out_tick;
	wire logic [1:0] out_ce;
	wire logic [1:0] out_clr;
	wire logic [1:0] wr;
	wire logic [1:0] otick;
	wire logic [1:0] oce;
	wire logic [1:0] oclr;
	wire logic [1:0] ld;
	wire logic [1:0] we_q;
	wire logic [1:0] we_eff;
	wire logic [1:0] rd_ok;
	wire logic [dpr_pkg::ADDR_W-1:0] addr [2];
	wire logic [dpr_pkg::ADDR_W-1:0] addr_q [2];
	wire logic [dpr_pkg::ADDR_W-1:0] eff_addr [2];
	wire logic [dpr_pkg::DATA_W-1:0] wdata [2];
	wire logic [dpr_pkg::DATA_W-1:0] data_q [2];
	wire logic [dpr_pkg::DATA_W-1:0] rd_word [2];
	wire logic [dpr_pkg::DATA_W-1:0] rdata [2];
	wire logic [dpr_pkg::LANES-1:0] boff [2];
	wire logic [dpr_pkg::LANES-1:0] boff_q [2];

	// Unused codes fall back to independent true dual-port behaviour
	assign mode = dpr_pkg::dpr_mode_type'(mode_in);
	assign is_io_true = (mode == dpr_pkg::DPR_IO_TRUE);
	assign is_io_simple = (mode == dpr_pkg::DPR_IO_SIMPLE);
	assign is_rw = (mode == dpr_pkg::DPR_RW_SIMPLE);
	assign is_single = (mode == dpr_pkg::DPR_SINGLE);
	assign is_simple = is_io_simple | is_rw;
	assign use_out_clk = is_io_true | is_io_simple;

	// Port A and port B each bring their own clock tick
	assign in_tick = {in_tick_b_in, in_tick_a_in};
	assign in_ce = {in_ce_b_in, in_ce_a_in};
	assign in_clr = {in_clr_b_in, in_clr_a_in};
	assign out_tick = {out_tick_b_in, out_tick_a_in};
	assign out_ce = {out_ce_b_in, out_ce_a_in};
	assign out_clr = {out_clr_b_in, out_clr_a_in};
	assign wr = {wr_b_in, wr_a_in};
	assign addr[0] = addr_a_in;
	assign addr[1] = addr_b_in;
	assign wdata[0] = wdata_a_in;
	assign wdata[1] = wdata_b_in;
	assign boff[0] = byte_off_a_in;
	assign boff[1] = byte_off_b_in;

	genvar p;
	generate
		for (p = 0; p < dpr_pkg::PORTS; p++)
		begin : g_port
			localparam logic PORT_HI = 1'(p);

			// Output stage uses its own clock, enable and clear only in in/out mode
			assign otick[p] = use_out_clk ? out_tick[p] : in_tick[p];
			assign oce[p] = use_out_clk ? out_ce[p] : in_ce[p];
			assign oclr[p] = use_out_clk ? out_clr[p] : in_clr[p];

			// Write side captures data, address and strobe on its own tick
			dpr_in_reg #(.W(dpr_pkg::IN_W)) u_in
			(
				.clk_sys_in(clk_sys_in),
				.reset_in(reset_in),
				.tick_in(in_tick[p]),
				.ce_in(in_ce[p]),
				.clr_in(in_clr[p]),
				.d_in({boff[p], wr[p], wdata[p], addr[p]}),
				.q_out({boff_q[p], we_q[p], data_q[p], addr_q[p]}),
				.load_out(ld[p])
			);

			// Port B is the read side in simple dual-port modes
			assign we_eff[p] = we_q[p] & ~(is_simple & PORT_HI);
			// One strobe picks read or write; simple modes read on the strobe
			assign rd_ok[p] = is_simple ? (PORT_HI & rden_q) : ~we_q[p];
			// Each single-port memory owns one half of the array
			assign eff_addr[p] = is_single ?
				{PORT_HI, addr_q[p][dpr_pkg::HALF_ADDR_W-1:0]} : addr_q[p];
			assign rd_word[p] = mem[eff_addr[p]];

			dpr_out_reg #(.W(dpr_pkg::DATA_W)) u_out
			(
				.clk_sys_in(clk_sys_in),
				.reset_in(reset_in),
				.tick_in(otick[p]),
				.ce_in(oce[p]),
				.clr_in(oclr[p]),
				.gate_in(rd_ok[p]),
				.d_in(rd_word[p]),
				.q_out(rdata[p])
			);
		end
	endgenerate

	assign rdata_a_out = rdata[0];
	assign rdata_b_out = rdata[1];

	// Read strobe register ignores the port clear by design
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			rden_q <= dpr_pkg::RDEN_RST;
		end
		else if (in_tick[1] && in_ce[1])
		begin
			rden_q <= rd_b_in;
		end
	end

	// Writes land one cycle after capture; port B wins a same-word collision
	always_ff @(posedge clk_sys_in)
	begin
		for (int i = 0; i < dpr_pkg::PORTS; i++)
		begin
			for (int l = 0; l < dpr_pkg::LANES; l++)
			begin
				if (ld[i] && we_eff[i] && !boff_q[i][l])
				begin
					mem[eff_addr[i]][l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] <=
						data_q[i][l*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
				end
			end
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	AST_OUT_CLR_A: assert property (
		oclr[0] |-> rdata_a_out == dpr_pkg::DATA_RST)
		else $error("port A output not zero under clear");

	AST_OUT_CLR_B: assert property (
		oclr[1] |-> rdata_b_out == dpr_pkg::DATA_RST)
		else $error("port B output not zero under clear");

	AST_IN_CLR_A: assert property (
		in_clr_a_in |-> (addr_q[0] == 8'h00) && !ld[0])
		else $error("port A input registers not cleared at once");

	AST_IN_CLR_B: assert property (
		in_clr_b_in |-> (addr_q[1] == 8'h00) && !ld[1])
		else $error("port B input registers not cleared at once");

	// Unwritten words may reach an output, so outputs are compared by identity
	AST_HOLD_B: assert property (
		!(otick[1] && oce[1]) && !oclr[1] |=> oclr[1] || rdata_b_out === $past(rdata_b_out))
		else $error("port B output moved without an enabled tick");

	AST_IN_HOLD_A: assert property (
		!(in_tick_a_in && in_ce_a_in) && !in_clr_a_in
		|=> in_clr_a_in || addr_q[0] == $past(addr_q[0]))
		else $error("port A input registers moved without an enabled tick");

	AST_NO_LOAD_A: assert property (
		!(in_tick_a_in && in_ce_a_in) |=> !ld[0])
		else $error("port A captured without an enabled tick");

	AST_NO_LOAD_B: assert property (
		!(in_tick_b_in && in_ce_b_in) |=> !ld[1])
		else $error("port B captured without an enabled tick");

	AST_LOAD_A: assert property (
		in_tick_a_in && in_ce_a_in && !in_clr_a_in |=> ld[0] || in_clr_a_in)
		else $error("port A capture missed an enabled tick");

	AST_LOAD_B: assert property (
		in_tick_b_in && in_ce_b_in && !in_clr_b_in |=> ld[1] || in_clr_b_in)
		else $error("port B capture missed an enabled tick");

	// Output stages in the in/out clock modes
	AST_IO_OUTCLK_A: assert property (
		is_io_true && out_tick_a_in && out_ce_a_in && !out_clr_a_in && !we_q[0]
		|=> out_clr_a_in || rdata_a_out === $past(rd_word[0]))
		else $error("port A output not loaded on its output clock");

	AST_IO_OUTCLK_B: assert property (
		is_io_simple && out_tick_b_in && out_ce_b_in && !out_clr_b_in && rden_q
		|=> out_clr_b_in || rdata_b_out === $past(rd_word[1]))
		else $error("port B output not loaded on its output clock");

	AST_OUT_CE_HOLD_A: assert property (
		use_out_clk && !(out_tick_a_in && out_ce_a_in) && !out_clr_a_in
		|=> out_clr_a_in || rdata_a_out === $past(rdata_a_out))
		else $error("port A output moved without its own enabled tick");

	AST_IND_A_READ: assert property (
		mode == dpr_pkg::DPR_IND && in_tick_a_in && in_ce_a_in && !in_clr_a_in && !we_q[0]
		|=> in_clr_a_in || rdata_a_out === $past(rd_word[0]))
		else $error("port A output not loaded on port A clock");

	AST_IND_B_READ: assert property (
		mode == dpr_pkg::DPR_IND && in_tick_b_in && in_ce_b_in && !in_clr_b_in && !we_q[1]
		|=> in_clr_b_in || rdata_b_out === $past(rd_word[1]))
		else $error("port B output not loaded on port B clock");

	AST_SINGLE_READ_B: assert property (
		is_single && in_tick_b_in && in_ce_b_in && !in_clr_b_in && !we_q[1]
		|=> in_clr_b_in || rdata_b_out === $past(rd_word[1]))
		else $error("single-port read on port B not loaded");

	AST_RDEN_NO_CLR: assert property (
		is_simple && in_clr_b_in && rden_q && !(in_tick_b_in && in_ce_b_in) |=> rden_q)
		else $error("read strobe register was cleared");

	AST_RDEN_LOAD: assert property (
		in_tick_b_in && in_ce_b_in |=> rden_q == $past(rd_b_in))
		else $error("read strobe register did not follow its tick");

	// Simple dual-port: A only writes, B only reads
	AST_WRITE_NO_READ_A: assert property (
		!is_simple && we_q[0] && !oclr[0] |=> oclr[0] || rdata_a_out === $past(rdata_a_out))
		else $error("port A output loaded during a write");

	AST_SIMPLE_A_HOLD: assert property (
		is_simple && !oclr[0] |=> oclr[0] || rdata_a_out === $past(rdata_a_out))
		else $error("port A output loaded in a simple dual-port mode");

	AST_SIMPLE_B_NO_WRITE: assert property (
		is_simple |-> !we_eff[1])
		else $error("read side wrote in a simple dual-port mode");

	AST_RW_GATED: assert property (
		is_rw && !rden_q && !oclr[1] |=> oclr[1] || rdata_b_out === $past(rdata_b_out))
		else $error("read side loaded without read strobe");

	AST_WRITE_LANDS: assert property (
		is_simple && ld[0] && we_q[0] && boff_q[0] == 2'h0
		|=> mem[$past(eff_addr[0])] == $past(data_q[0]))
		else $error("full-width write did not land");

	AST_SINGLE_SPLIT: assert property (
		is_single |-> !eff_addr[0][7] && eff_addr[1][7])
		else $error("single-port halves overlap");

	COV_IND_READ_B: cover property (
		mode == dpr_pkg::DPR_IND && ld[1] && !we_q[1] ##1 otick[1] && oce[1]);
	COV_SIMPLE_WRITE: cover property (is_rw && ld[0] && we_eff[0]);
	COV_SIMPLE_READ: cover property (is_io_simple && rden_q && out_tick_b_in && out_ce_b_in);
	COV_SINGLE_B_WRITE: cover property (is_single && ld[1] && we_eff[1]);
	COV_OUT_TICK_ONLY_A: cover property (is_io_true && out_tick_a_in && out_ce_a_in && !in_tick_a_in);
endmodule
`default_nettype wire

// >>> core/dpr_pkg.sv
package dpr_pkg;

	// Storage shape of the block
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int DEPTH = 256;
	localparam int PORTS = 2;

	// Each single-port memory holds 128 x 16 = 2K bits
	localparam int HALF_ADDR_W = 7;
	localparam int SINGLE_BITS = 2048;

	// Width of the captured input bundle: lane offs, write strobe, data, address
	localparam int IN_W = LANES + 1 + DATA_W + ADDR_W;

	// Values after reset
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic RDEN_RST = 1'h0;

	typedef enum logic [2:0]
	{
		DPR_IND = 3'h0,
		DPR_IO_TRUE = 3'h1,
		DPR_IO_SIMPLE = 3'h2,
		DPR_RW_SIMPLE = 3'h3,
		DPR_SINGLE = 3'h4
	} dpr_mode_type;

endpackage

// >>> core/dpr_in_reg.sv
`timescale 1ns/1ns
`default_nettype none
module dpr_in_reg
#(
	parameter int W = 1
)
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic tick_in,
	input wire logic ce_in,
	input wire logic clr_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out,
	output logic load_out
);
	logic [W-1:0] q;
	logic load;

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || clr_in)
		begin
			q <= '0;
			load <= 1'b0;
		end
		else
		begin
			load <= tick_in & ce_in;
			if (tick_in && ce_in)
			begin
				q <= d_in;
			end
		end
	end

	// Clear masks the output at once; the flops follow on the next edge
	assign q_out = clr_in ? '0 : q;
	// A cleared capture must never reach the array
	assign load_out = load & ~clr_in;
endmodule
`default_nettype wire

// >>> core/dpr_out_reg.sv
`timescale 1ns/1ns
`default_nettype none
module dpr_out_reg
#(
	parameter int W = 1
)
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic tick_in,
	input wire logic ce_in,
	input wire logic clr_in,
	input wire logic gate_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] q;

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || clr_in)
		begin
			q <= '0;
		end
		else if (tick_in && ce_in && gate_in)
		begin
			q <= d_in;
		end
	end

	assign q_out = clr_in ? '0 : q;
endmodule
`default_nettype wire

// >>> verif/dpr_fabric.sv
`timescale 1ns/1ns
`default_nettype none
module dpr_fabric
(
	input wire logic clk_sys_in,
	output logic tick_out,
	output logic ce_out,
	output logic clr_out,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out,
	output logic wr_out,
	output logic [1:0] off_out,
	output logic rd_out
);
	initial
	begin
		tick_out = 1'h0;
		ce_out = 1'h1;
		clr_out = 1'h0;
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'h0;
		off_out = 2'h0;
		rd_out = 1'h0;
	end
	task automatic set_ctl(input logic ce, input logic clr);
		ce_out <= ce;
		clr_out <= clr;
	endtask
	// Released address and data show inverted values so a late sample never matches by luck
	task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] o, input logic r, input int n);
		@(posedge clk_sys_in);
		wr_out <= w;
		addr_out <= a;
		wdata_out <= d;
		off_out <= o;
		rd_out <= r;
		tick_out <= 1'h1;
		repeat (n) @(posedge clk_sys_in);
		tick_out <= 1'h0;
		wr_out <= 1'h0;
		addr_out <= ~a;
		wdata_out <= ~d;
		off_out <= 2'h0;
		rd_out <= 1'h0;
	endtask
endmodule
`default_nettype wire

// >>> verif/dpr_ram_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dpr_ram_tb;
	logic clk_sys_in = 1'h0;
	logic reset_in = 1'h1;
	logic [2:0] mode = 3'h0;
	logic [15:0] rda, rdb, d;
	logic [15:0] mem [256];
	logic [7:0] a;
	logic [1:0] o;
	int mismatches = 0;
	int n_checks = 0;
	int seed = 60;
	logic a_tick, a_ce, a_clr, a_wr, b_tick, b_ce, b_clr, b_wr, b_rd;
	logic [7:0] a_addr, b_addr;
	logic [15:0] a_wd, b_wd;
	logic [1:0] a_off, b_off;
	// Extra port A output-stage controls, felt only in the in/out clock modes
	logic x_tick = 1'h0, x_ce = 1'h1, x_clr = 1'h0;
	always #10 clk_sys_in = ~clk_sys_in;
	dpr_fabric pa(.clk_sys_in(clk_sys_in), .tick_out(a_tick), .ce_out(a_ce), .clr_out(a_clr),
		.addr_out(a_addr), .wdata_out(a_wd), .wr_out(a_wr), .off_out(a_off), .rd_out());
	dpr_fabric pb(.clk_sys_in(clk_sys_in), .tick_out(b_tick), .ce_out(b_ce), .clr_out(b_clr),
		.addr_out(b_addr), .wdata_out(b_wd), .wr_out(b_wr), .off_out(b_off), .rd_out(b_rd));
	dpr_ram dpr_ram_inst(.clk_sys_in(clk_sys_in), .reset_in(reset_in), .mode_in(mode),
		.in_tick_a_in(a_tick), .in_ce_a_in(a_ce), .in_clr_a_in(a_clr),
		.out_tick_a_in(a_tick | x_tick), .out_ce_a_in(a_ce & x_ce), .out_clr_a_in(a_clr | x_clr),
		.addr_a_in(a_addr), .wdata_a_in(a_wd), .wr_a_in(a_wr), .byte_off_a_in(a_off),
		.rdata_a_out(rda), .in_tick_b_in(b_tick), .in_ce_b_in(b_ce), .in_clr_b_in(b_clr),
		.out_tick_b_in(b_tick), .out_ce_b_in(b_ce), .out_clr_b_in(b_clr),
		.addr_b_in(b_addr), .wdata_b_in(b_wd), .wr_b_in(b_wr), .byte_off_b_in(b_off),
		.rd_b_in(b_rd), .rdata_b_out(rdb));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Suppressed lanes keep the old byte
	function automatic logic [15:0] merge(input logic [15:0] p, input logic [15:0] q,
		input logic [1:0] f);
		return {f[1] ? p[15:8] : q[15:8], f[0] ? p[7:0] : q[7:0]};
	endfunction
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'h0;
		#1 chk("rdata_a reset", rda, 16'h0000);
		chk("rdata_b reset", rdb, 16'h0000);
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk_sys_in) mode <= 3'(m);
			for (int i = 0; i < 6; i++)
			begin
				a = 8'($random(seed));
				d = 16'($random(seed));
				o = (i < 2) ? 2'h0 : 2'($random(seed));
				pa.op(1'h1, a, ~d, 2'h0, 1'h0, 1);
				pa.op(1'h1, a, d, o, 1'h0, 1);
				mem[a] = merge(~d, d, o);
				pb.op(1'h0, a, 16'h0000, 2'h0, 1'h0, 2);
				#1 chk("rdata_b", rdb, mem[a]);
				pa.op(1'h0, a, 16'h0000, 2'h0, 1'h0, 2);
				#1 chk("rdata_a", rda, mem[a]);
			end
		end
		@(posedge clk_sys_in) pa.set_ctl(1'h0, 1'h0);
		pa.op(1'h0, a ^ 8'h01, 16'h0000, 2'h0, 1'h0, 2);
		#1 chk("rdata_a hold", rda, mem[a]);
		@(posedge clk_sys_in) pa.set_ctl(1'h1, 1'h1);
		#1 chk("rdata_a clear", rda, 16'h0000);
		chk("rdata_b other port", rdb, mem[a]);
		@(posedge clk_sys_in) pa.set_ctl(1'h1, 1'h0);
		// Input capture with the output enable off, then an output tick alone
		@(posedge clk_sys_in) x_ce <= 1'h0;
		pa.op(1'h0, a, 16'h0000, 2'h0, 1'h0, 1);
		#1 chk("rdata_a output enable off", rda, 16'h0000);
		@(posedge clk_sys_in) x_ce <= 1'h1;
		x_tick <= 1'h1;
		@(posedge clk_sys_in) x_tick <= 1'h0;
		#1 chk("rdata_a output clock", rda, mem[a]);
		@(posedge clk_sys_in) x_clr <= 1'h1;
		#1 chk("rdata_a output clear", rda, 16'h0000);
		@(posedge clk_sys_in) x_clr <= 1'h0;
		x_tick <= 1'h1;
		@(posedge clk_sys_in) x_tick <= 1'h0;
		#1 chk("rdata_a input kept", rda, mem[a]);
		for (int m = 2; m < 4; m++)
		begin
			@(posedge clk_sys_in) mode <= 3'(m);
			a = 8'($random(seed));
			d = 16'($random(seed));
			pa.op(1'h1, a, d, 2'h0, 1'h0, 1);
			pb.op(1'h0, a, 16'h0000, 2'h0, 1'h1, 2);
			#1 chk("rdata_b simple", rdb, d);
			pb.op(1'h0, a ^ 8'h01, 16'h0000, 2'h0, 1'h0, 2);
			#1 chk("rdata_b no strobe", rdb, d);
		end
		// A read-side clear must leave the registered read strobe set
		pa.op(1'h1, 8'h00, ~d, 2'h0, 1'h0, 1);
		pb.op(1'h0, a, 16'h0000, 2'h0, 1'h1, 1);
		@(posedge clk_sys_in) pb.set_ctl(1'h1, 1'h1);
		@(posedge clk_sys_in) pb.set_ctl(1'h1, 1'h0);
		#1 chk("rdata_b read clear", rdb, 16'h0000);
		pb.op(1'h0, a, 16'h0000, 2'h0, 1'h0, 1);
		#1 chk("rdata_b strobe kept", rdb, ~d);
		@(posedge clk_sys_in) mode <= 3'h4;
		pa.op(1'h1, 8'h05, 16'h1234, 2'h0, 1'h0, 1);
		pb.op(1'h1, 8'h85, 16'hABCD, 2'h0, 1'h0, 1);
		pa.op(1'h0, 8'h85, 16'h0000, 2'h0, 1'h0, 2);
		#1 chk("rdata_a single", rda, 16'h1234);
		pb.op(1'h0, 8'h05, 16'h0000, 2'h0, 1'h0, 2);
		#1 chk("rdata_b single", rdb, 16'hABCD);
		report_and_stop();
	end
endmodule
`default_nettype wire
